// ==== core/hw_xfer_pkg.sv ====
// package for the half-word and signed transfer decoder
// assumes one core clock and an apb master that owns the register map
package hw_xfer_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_BASE = 8'h08;
	localparam logic [7:0] OFF_OFFSET = 8'h0c;
	localparam logic [7:0] OFF_SOURCE = 8'h10;
	localparam logic [7:0] OFF_BUS_RDATA = 8'h14;
	localparam logic [7:0] OFF_CTRL = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_ADDR = 8'h20;
	localparam logic [7:0] OFF_LOAD_RESULT = 8'h24;
	localparam logic [7:0] OFF_STORE_DATA = 8'h28;
	localparam logic [7:0] OFF_FIELDS = 8'h2c;

	// ****************************************
	// instruction field positions
	// ****************************************
	localparam int POS_COND = 28;
	localparam int POS_PRE = 24;
	localparam int POS_UP = 23;
	localparam int POS_IMM = 22;
	localparam int POS_WBACK = 21;
	localparam int POS_LOAD = 20;
	localparam int POS_BASE = 16;
	localparam int POS_DEST = 12;
	localparam int POS_IMM_HI = 8;
	localparam int POS_SIGN = 6;
	localparam int POS_HALF = 5;
	localparam int POS_IMM_LO = 0;
	localparam int POS_OFFSET_REG = 0;

	// ****************************************
	// flag, control and status bit positions
	// ****************************************
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 0;
	localparam int CTRL_ENDIAN = 0;
	localparam int CTRL_GO = 1;
	localparam int ST_DONE = 0;
	localparam int ST_EXECUTED = 1;
	localparam int ST_LOAD = 2;
	localparam int ST_WROTE_BACK = 3;
	localparam int ST_SWAP = 4;
	localparam int ST_SIGNED_STORE = 5;
	localparam int ST_LANE = 6;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam logic [1:0] RST_LANE = 2'h0;

	// decoded instruction fields
	typedef struct packed {
		logic [3:0] cond;
		logic pre;
		logic up;
		logic imm;
		logic wback;
		logic load;
		logic [3:0] base_reg_field;
		logic [3:0] dest_reg_field;
		logic sign;
		logic half;
		logic [3:0] offset_reg_field;
		logic [7:0] imm8;
	} decode_t;

endpackage

// ==== core/cond_check.sv ====
// condition field evaluation against the current flags
// assumes flags arrive as n z c v in bits 3 down to 0
`timescale 1ns/100ps
`default_nettype none
module cond_check (
	input wire logic [3:0] cond_i,
	input wire logic [3:0] flags_i,
	output logic pass_o
);
	logic n, z, c, v;
	assign n = flags_i[hw_xfer_pkg::FLAG_N];
	assign z = flags_i[hw_xfer_pkg::FLAG_Z];
	assign c = flags_i[hw_xfer_pkg::FLAG_C];
	assign v = flags_i[hw_xfer_pkg::FLAG_V];

	// fifteen conditions plus the never pattern
	always_comb begin
		case (cond_i)
			4'h0: pass_o = z;
			4'h1: pass_o = !z;
			4'h2: pass_o = c;
			4'h3: pass_o = !c;
			4'h4: pass_o = n;
			4'h5: pass_o = !n;
			4'h6: pass_o = v;
			4'h7: pass_o = !v;
			4'h8: pass_o = c && !z;
			4'h9: pass_o = !c || z;
			4'ha: pass_o = (n == v);
			4'hb: pass_o = (n != v);
			4'hc: pass_o = !z && (n == v);
			4'hd: pass_o = z || (n != v);
			4'he: pass_o = 1'b1;
			default: pass_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ==== core/load_extend.sv ====
// data bus lane selection and zero or sign extension of loaded data
// assumes a half-word aligned address for half-word loads
`timescale 1ns/100ps
`default_nettype none
module load_extend (
	input wire logic [31:0] word_i,
	input wire logic [1:0] addr_lo_i,
	input wire logic big_i,
	input wire logic sign_i,
	input wire logic half_i,
	output logic [31:0] data_o
);
	logic [1:0] lane;
	logic [7:0] byte_sel;
	logic [15:0] half_sel;

	// lane order flips with the endian select
	always_comb begin
		lane = big_i ? ~addr_lo_i : addr_lo_i;
		case (lane)
			2'h0: byte_sel = word_i[7:0];
			2'h1: byte_sel = word_i[15:8];
			2'h2: byte_sel = word_i[23:16];
			default: byte_sel = word_i[31:24];
		endcase
		half_sel = lane[1] ? word_i[31:16] : word_i[15:0];
	end

	// zero fill for unsigned, sign bit fill for signed
	always_comb begin
		if (half_i) begin
			data_o = {{16{sign_i & half_sel[15]}}, half_sel};
		end else begin
			data_o = {{24{sign_i & byte_sel[7]}}, byte_sel};
		end
	end
endmodule
`default_nettype wire

// ==== core/hw_xfer_decode.sv ====
// half-word and signed byte transfer decode and execute, apb slave
// assumes an apb master on clk_i and a memory that enables only the addressed half
// Functional notes
// - execute only when condition passes
// - address is base plus or minus offset
// - offset from 8-bit immediate or register
// - immediate is bits 11:8 then 3:0
// - up bit adds, otherwise subtracts
// - pre bit offsets before use as address
// - pre-indexed writes back only when w set
// - post-indexed always writes back base
// - s low h high moves unsigned half
// - s high loads signed byte or half
// - signed byte fills 31:8 with bit 7
// - signed half fills 31:16 with bit 15
// - lane depends on endian select
// - little endian half uses a1 lane
// - big endian half lanes are reversed
// - half store drives both bus halves
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module hw_xfer_decode (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	// ****************************************
	// registers and decode
	// ****************************************
	logic [31:0] instr;
	logic [3:0] flags;
	logic [31:0] base_val;
	logic [31:0] offset_val;
	logic [31:0] source_val;
	logic [31:0] bus_rdata;
	logic endian_select_input;
	logic [31:0] addr_r;
	logic [31:0] load_result;
	logic [31:0] store_data;
	logic done, executed, was_load, wrote_back, swap_seen, signed_store;
	logic [1:0] lane_en;
	hw_xfer_pkg::decode_t dec;
	logic setup, complete, wr, go, pass, is_swap, bad_store, run;
	logic [31:0] offset, modified, xfer_addr, extended, rd_mux;
	logic do_wb, mapped;

	always_comb begin
		dec.cond = instr[hw_xfer_pkg::POS_COND +: 4];
		dec.pre = instr[hw_xfer_pkg::POS_PRE];
		dec.up = instr[hw_xfer_pkg::POS_UP];
		dec.imm = instr[hw_xfer_pkg::POS_IMM];
		dec.wback = instr[hw_xfer_pkg::POS_WBACK];
		dec.load = instr[hw_xfer_pkg::POS_LOAD];
		dec.base_reg_field = instr[hw_xfer_pkg::POS_BASE +: 4];
		dec.dest_reg_field = instr[hw_xfer_pkg::POS_DEST +: 4];
		dec.sign = instr[hw_xfer_pkg::POS_SIGN];
		dec.half = instr[hw_xfer_pkg::POS_HALF];
		dec.offset_reg_field = instr[hw_xfer_pkg::POS_OFFSET_REG +: 4];
		dec.imm8 = {instr[hw_xfer_pkg::POS_IMM_HI +: 4], instr[hw_xfer_pkg::POS_IMM_LO +: 4]};
	end

	cond_check u_cond (
		.cond_i(dec.cond),
		.flags_i(flags),
		.pass_o(pass)
	);

	// ****************************************
	// address arithmetic
	// ****************************************
	always_comb begin
		offset = dec.imm ? {24'h00_0000, dec.imm8} : offset_val;
		modified = dec.up ? base_val + offset : base_val - offset;
		// pre uses modified base, post the old one
		xfer_addr = dec.pre ? modified : base_val;
		// post-indexed ignores w and writes back
		do_wb = dec.pre ? dec.wback : 1'b1;
	end

	// size zero is the swap class
	assign is_swap = !dec.sign && !dec.half;
	assign bad_store = dec.sign && !dec.load;

	load_extend u_ext (
		.word_i(bus_rdata),
		.addr_lo_i(xfer_addr[1:0]),
		.big_i(endian_select_input),
		.sign_i(dec.sign),
		.half_i(dec.half),
		.data_o(extended)
	);

	// ****************************************
	// apb slave
	// ****************************************
	assign setup = psel_i && penable_i && !pready_o;
	assign complete = psel_i && penable_i && pready_o;
	assign wr = complete && pwrite_i;
	assign go = wr && paddr_i == hw_xfer_pkg::OFF_CTRL && pwdata_i[hw_xfer_pkg::CTRL_GO];
	assign run = go && pass && !is_swap && !bad_store;

	// read mux, unmapped addresses flag an error
	always_comb begin
		mapped = 1'b1;
		case (paddr_i)
			hw_xfer_pkg::OFF_INSTR: rd_mux = instr;
			hw_xfer_pkg::OFF_FLAGS: rd_mux = {28'h000_0000, flags};
			hw_xfer_pkg::OFF_BASE: rd_mux = base_val;
			hw_xfer_pkg::OFF_OFFSET: rd_mux = offset_val;
			hw_xfer_pkg::OFF_SOURCE: rd_mux = source_val;
			hw_xfer_pkg::OFF_BUS_RDATA: rd_mux = bus_rdata;
			hw_xfer_pkg::OFF_CTRL: rd_mux = {31'h0000_0000, endian_select_input};
			hw_xfer_pkg::OFF_STATUS: rd_mux = {24'h00_0000, lane_en, signed_store, swap_seen,
				wrote_back, was_load, executed, done};
			hw_xfer_pkg::OFF_ADDR: rd_mux = addr_r;
			hw_xfer_pkg::OFF_LOAD_RESULT: rd_mux = load_result;
			hw_xfer_pkg::OFF_STORE_DATA: rd_mux = store_data;
			hw_xfer_pkg::OFF_FIELDS: rd_mux = {8'h00, dec.cond, dec.base_reg_field,
				dec.dest_reg_field, dec.offset_reg_field, dec.imm8};
			default: begin
				rd_mux = hw_xfer_pkg::RST_WORD;
				mapped = 1'b0;
			end
		endcase
	end

	// one wait state, answer registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			prdata_o <= hw_xfer_pkg::RST_WORD;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= setup;
			prdata_o <= (setup && !pwrite_i) ? rd_mux : hw_xfer_pkg::RST_WORD;
			pslverr_o <= setup && !mapped;
		end
	end

	// software written operand registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr <= hw_xfer_pkg::RST_WORD;
			flags <= hw_xfer_pkg::RST_FLAGS;
			offset_val <= hw_xfer_pkg::RST_WORD;
			source_val <= hw_xfer_pkg::RST_WORD;
			bus_rdata <= hw_xfer_pkg::RST_WORD;
			endian_select_input <= 1'b0;
		end else if (wr) begin
			case (paddr_i)
				hw_xfer_pkg::OFF_INSTR: instr <= pwdata_i;
				hw_xfer_pkg::OFF_FLAGS: flags <= pwdata_i[3:0];
				hw_xfer_pkg::OFF_OFFSET: offset_val <= pwdata_i;
				hw_xfer_pkg::OFF_SOURCE: source_val <= pwdata_i;
				hw_xfer_pkg::OFF_BUS_RDATA: bus_rdata <= pwdata_i;
				hw_xfer_pkg::OFF_CTRL: endian_select_input <= pwdata_i[hw_xfer_pkg::CTRL_ENDIAN];
				default: ;
			endcase
		end
	end

	// base register, software write or auto-index write-back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_val <= hw_xfer_pkg::RST_WORD;
		end else if (run && do_wb) begin
			base_val <= modified;
		end else if (wr && paddr_i == hw_xfer_pkg::OFF_BASE) begin
			base_val <= pwdata_i;
		end
	end

	// ****************************************
	// execution results
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_r <= hw_xfer_pkg::RST_WORD;
			load_result <= hw_xfer_pkg::RST_WORD;
			store_data <= hw_xfer_pkg::RST_WORD;
			lane_en <= hw_xfer_pkg::RST_LANE;
			was_load <= 1'b0;
			wrote_back <= 1'b0;
		end else if (run) begin
			addr_r <= xfer_addr;
			was_load <= dec.load;
			wrote_back <= do_wb;
			// unsigned half load zero fills, store repeats
			if (dec.load) begin
				load_result <= extended;
				store_data <= hw_xfer_pkg::RST_WORD;
				lane_en <= hw_xfer_pkg::RST_LANE;
			end else begin
				// low half on both bus halves
				store_data <= {source_val[15:0], source_val[15:0]};
				lane_en <= (xfer_addr[1] ^ endian_select_input) ? 2'h2 : 2'h1;
			end
		end
	end

	// status: executed and rejection flags follow each go, done is sticky
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			executed <= 1'b0;
			swap_seen <= 1'b0;
			signed_store <= 1'b0;
		end else if (go) begin
			executed <= run;
			swap_seen <= is_swap;
			signed_store <= bad_store && !is_swap;
		end
	end

	// done set wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done <= 1'b0;
		end else if (go) begin
			done <= 1'b1;
		end else if (wr && paddr_i == hw_xfer_pkg::OFF_STATUS && pwdata_i[hw_xfer_pkg::ST_DONE]) begin
			done <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_go_run;
		go && pass && !is_swap && !bad_store;
	endsequence

	sequence s_go_blocked;
		go && !pass;
	endsequence

	a_cond_blocks: assert property (s_go_blocked |=> !executed && $stable(base_val))
		else $error("failed condition still executed");
	a_pre_address: assert property (s_go_run ##0 dec.pre |=>
		addr_r == $past(modified) && addr_r == $past(xfer_addr))
		else $error("pre-indexed address wrong");
	a_post_address: assert property (s_go_run ##0 !dec.pre |=>
		addr_r == $past(base_val) && base_val == $past(modified) && wrote_back)
		else $error("post-indexed address or write-back wrong");
	a_imm_offset: assert property (s_go_run ##0 (dec.imm && dec.up && dec.pre) |=>
		addr_r == $past(base_val) + {24'h00_0000, $past(instr[11:8]), $past(instr[3:0])})
		else $error("immediate offset wrong");
	a_down_subtract: assert property (s_go_run ##0 (!dec.imm && !dec.up && dec.pre) |=>
		addr_r == $past(base_val) - $past(offset_val))
		else $error("down offset not subtracted");
	a_pre_keep_base: assert property (s_go_run ##0 (dec.pre && !dec.wback) |=>
		base_val == $past(base_val) && !wrote_back)
		else $error("base changed without write-back");
	a_sbyte_extend: assert property (s_go_run ##0 (dec.load && dec.sign && !dec.half) |=>
		load_result[31:8] == {24{load_result[7]}})
		else $error("signed byte not sign extended");
	a_shalf_extend: assert property (s_go_run ##0 (dec.load && dec.sign && dec.half) |=>
		load_result[31:16] == {16{load_result[15]}})
		else $error("signed half not sign extended");
	a_uhalf_lane: assert property (s_go_run ##0 (dec.load && !dec.sign) |=>
		load_result == {16'h0000, (addr_r[1] ^ $past(endian_select_input)) ?
		$past(bus_rdata[31:16]) : $past(bus_rdata[15:0])})
		else $error("unsigned half lane or fill wrong");
	a_store_repeat: assert property (s_go_run ##0 !dec.load |=>
		store_data == {2{$past(source_val[15:0])}} && lane_en != 2'h0)
		else $error("half store data not repeated");
	a_swap_reject: assert property (go && is_swap |=> !executed && swap_seen ##1 done)
		else $error("swap pattern was decoded");

	sequence s_go_refused;
		go && (bad_store || is_swap);
	endsequence

	a_refused_hold: assert property (s_go_refused |=> !executed && $stable(base_val)
		&& $stable(addr_r))
		else $error("refused pattern changed state");
	a_signed_reject: assert property (go && bad_store |=> signed_store && !swap_seen)
		else $error("signed store not flagged");
	a_results_hold: assert property (s_go_blocked |=> $stable(load_result)
		&& $stable(store_data) && $stable(addr_r))
		else $error("blocked transfer changed results");
	a_store_lane: assert property (s_go_run ##0 !dec.load |=>
		lane_en == (($past(xfer_addr[1]) ^ $past(endian_select_input)) ? 2'h2 : 2'h1))
		else $error("store half enable wrong");
endmodule
`default_nettype wire

// ==== testbench/mem_model.sv ====
// memory system model on the far side of the transfer decoder
// assumes the bench presents the transfer address, half enables and store word
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input wire logic clk_i,
	input wire logic [31:0] addr_i,
	input wire logic we_i,
	input wire logic [1:0] lanes_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o
);
	// ****************************************
	// storage
	// ****************************************
	logic [31:0] mem [16];
	// fixed fill so loads see both sign polarities
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'h80f1_7f02 ^ (32'h1357_9bdf * i);
		end
	end
	// word read by index
	assign rdata_o = mem[addr_i[5:2]];
	always @(posedge clk_i) begin
		if (we_i && lanes_i[0]) begin
			mem[addr_i[5:2]][15:0] <= wdata_i[15:0];
		end
		if (we_i && lanes_i[1]) begin
			mem[addr_i[5:2]][31:16] <= wdata_i[31:16];
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the half-word and signed transfer decoder
// assumes the apb slave answers in bounded time and the memory model above
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [31:0] CORNER [4] = '{32'he000_0090, 32'he000_00d0, 32'hf010_00b0,
		32'he170_0fdf};
	logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, mem_we;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
	logic [1:0] mem_lanes;
	int error_cnt, checked, cycles;

	hw_xfer_decode uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));
	mem_model mem (.clk_i(clk_i), .addr_i(mem_addr), .we_i(mem_we), .lanes_i(mem_lanes),
		.wdata_i(mem_wdata), .rdata_o(mem_rdata));

	// ****************************************
	// clock, timeout and reporting
	// ****************************************
	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// ****************************************
	// expected values
	// ****************************************
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[2];
			3'h1: r = f[1];
			3'h2: r = f[3];
			3'h3: r = f[0];
			3'h4: r = f[1] & ~f[2];
			3'h5: r = f[3] == f[0];
			3'h6: r = ~f[2] & (f[3] == f[0]);
			default: r = 1'h1;
		endcase
		return (c == 4'hf) ? 1'h0 : r ^ c[0];
	endfunction
	function automatic logic [31:0] ext_load(input logic [31:0] w, input logic [1:0] a,
		input logic big, input logic s, input logic h);
		logic [15:0] hw;
		logic [7:0] b;
		hw = (a[1] ^ big) ? w[31:16] : w[15:0];
		b = w[8 * (big ? 3 - a : a) +: 8];
		if (h) begin
			return s ? {{16{hw[15]}}, hw} : {16'h0, hw};
		end
		return {{24{b[7]}}, b};
	endfunction

	// one instruction: load registers, set endian, go, then check results
	task automatic run_one(input logic [31:0] ins, input logic [3:0] fl, input logic [31:0] base,
		input logic [31:0] offr, input logic [31:0] src, input logic big);
		logic [31:0] off, moved, addr, word, rd;
		logic [31:0] vals [5];
		logic [7:0] st;
		logic err, go, wb, ld;
		logic [1:0] lanes;
		off = ins[22] ? {24'h0, ins[11:8], ins[3:0]} : offr;
		moved = ins[23] ? base + off : base - off;
		addr = ins[24] ? moved : base;
		wb = ins[24] ? ins[21] : 1'h1;
		ld = ins[20];
		go = cond_ok(ins[31:28], fl) && (ins[6] || ins[5]) && !(ins[6] && !ld);
		lanes = ld ? 2'h0 : ((addr[1] ^ big) ? 2'h2 : 2'h1);
		mem_addr <= addr;
		vals = '{ins, {28'h0, fl}, base, offr, src};
		for (int i = 0; i < 5; i++) begin
			apb(1'h1, hw_xfer_pkg::OFF_INSTR + 8'(4 * i), vals[i], rd, err);
		end
		word = mem_rdata;
		apb(1'h1, hw_xfer_pkg::OFF_BUS_RDATA, word, rd, err);
		apb(1'h1, hw_xfer_pkg::OFF_CTRL, {31'h0, big}, rd, err);
		apb(1'h1, hw_xfer_pkg::OFF_CTRL, {30'h0, 1'h1, big}, rd, err);
		apb(1'h0, hw_xfer_pkg::OFF_STATUS, 32'h0, rd, err);
		st = rd[7:0];
		chk("executed", {31'h0, st[1]}, {31'h0, go});
		apb(1'h0, hw_xfer_pkg::OFF_BASE, 32'h0, rd, err);
		chk("base", rd, (go && wb) ? moved : base);
		apb(1'h0, hw_xfer_pkg::OFF_FIELDS, 32'h0, rd, err);
		chk("fields", rd, {8'h0, ins[31:28], ins[19:16], ins[15:12], ins[3:0], ins[11:8], ins[3:0]});
		if (ins[6:5] == 2'h0) begin
			chk("swap flag", {31'h0, st[4]}, 32'h1);
		end
		if (ins[6] && !ld) begin
			chk("signed store flag", {31'h0, st[5]}, 32'h1);
		end
		if (go) begin
			chk("status", {24'h0, st}, {24'h0, lanes, 2'h0, wb, ld, 2'h3});
			apb(1'h0, hw_xfer_pkg::OFF_ADDR, 32'h0, rd, err);
			chk("address", rd, addr);
			if (ld) begin
				apb(1'h0, hw_xfer_pkg::OFF_LOAD_RESULT, 32'h0, rd, err);
				chk("load", rd, ext_load(word, addr[1:0], big, ins[6], ins[5]));
			end else begin
				apb(1'h0, hw_xfer_pkg::OFF_STORE_DATA, 32'h0, rd, err);
				chk("store data", rd, {src[15:0], src[15:0]});
				mem_wdata <= rd;
				mem_lanes <= st[7:6];
				mem_we <= 1'h1;
				@(posedge clk_i);
				mem_we <= 1'h0;
				@(posedge clk_i);
				chk("memory", mem_rdata, lanes[1] ? {src[15:0], word[15:0]} : {word[31:16], src[15:0]});
			end
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] ins, rd;
		logic err;
		rst_i = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		mem_addr = 32'h0;
		mem_we = 1'h0;
		mem_lanes = 2'h0;
		mem_wdata = 32'h0;
		error_cnt = 0;
		checked = 0;
		cycles = 0;
		void'($urandom(47));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		// every register reads zero after reset
		for (int i = 0; i < 12; i++) begin
			apb(1'h0, 8'(4 * i), 32'h0, rd, err);
			chk("reset value", rd, 32'h0);
		end
		// unmapped place: write ignored, read zero with error
		apb(1'h1, 8'h40, 32'hffff_ffff, rd, err);
		apb(1'h0, 8'h30, 32'h0, rd, err);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		// swap pattern, signed store, never condition, borrow at base zero
		for (int i = 0; i < 4; i++) begin
			run_one(CORNER[i], 4'h0, 32'h0, 32'h4, $urandom(), 1'(i));
		end
		for (int k = 0; k < 150; k++) begin
			ins = $urandom();
			ins[27:25] = 3'h0;
			ins[7] = 1'h1;
			ins[4] = 1'h1;
			if (k % 2 == 0) begin
				ins[31:28] = 4'he;
			end
			if (ins[6:5] == 2'h0) begin
				ins[5] = 1'h1;
			end
			if (ins[6]) begin
				ins[20] = 1'h1;
			end
			if (!ins[24]) begin
				ins[21] = 1'h0;
			end
			run_one(ins, 4'($urandom()), $urandom(), $urandom_range(0, 300), $urandom(),
				1'($urandom()));
		end
		// done flag clears on write of one
		apb(1'h1, hw_xfer_pkg::OFF_STATUS, 32'h1, rd, err);
		apb(1'h0, hw_xfer_pkg::OFF_STATUS, 32'h0, rd, err);
		chk("done clear", {31'h0, rd[0]}, 32'h0);
		// mid-run reset brings every register back to zero
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int i = 0; i < 12; i++) begin
			apb(1'h0, 8'(4 * i), 32'h0, rd, err);
			chk("reset again", rd, 32'h0);
		end
		summarize();
	end
endmodule
`default_nettype wire
